// ==== design/pibc_top.v ====
// phy setup control register bank with routine engines and status
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "pibc_defines.vh"
module pibc_top (
	input wire mclk_i,
	input wire sys_rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output wire wb_ack_o,
	input wire [7:0] lane_status_set_i,
	output reg pll_passthrough_o,
	output reg controller_dram_setup_o,
	output reg irq_o
);
	////////////////////////////////////////////////////////////////////////
	reg [31:0] ctrl_reg;
	reg [31:0] ctrl_next;
	reg [3:0] status_reg;
	reg [3:0] status_next;
	reg [7:0] lane_reg;
	reg [7:0] lane_next;
	reg [3:0] irq_stat_reg;
	reg [3:0] irq_mask_reg;
	reg auto_reg;
	reg [31:0] wdata;
	reg [31:0] rdata;
	wire bus_wr;
	wire bus_rd;
	wire ctrl_wr;
	wire launch;
	wire impedance_cal_request_busy;
	wire impedance_cal_request_done;
	wire delay_line_cal_request_busy;
	wire delay_line_cal_request_done;
	wire lock_busy;
	wire lock_done;
	wire impedance_cal_request_start;
	wire delay_line_cal_request_start;
	wire lock_start;
	wire impedance_cal_request_stop;
	wire delay_line_cal_request_stop;
	wire lock_stop;
	wire [3:0] events;
	wire irq_wr;
	wire mask_wr;
	wire wipe_wr;
	wire train_launch;
	wire engines_idle;
	integer i;

	function [31:0] sel_merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] sel;
		integer k;
		begin
			sel_merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (sel[k]) begin
					sel_merge[k*8 +: 8] = nw[k*8 +: 8];
				end
			end
		end
	endfunction

	// true when the bus address selects the given register
	function adr_hit;
		input [3:0] adr;
		input [3:0] ofs;
		begin
			adr_hit = (adr == ofs);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	pibc_wb_slave u_wb (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.cyc_i(wb_cyc_i),
		.stb_i(wb_stb_i),
		.we_i(wb_we_i),
		.ack_o(wb_ack_o),
		.wr_o(bus_wr),
		.rd_o(bus_rd)
	);

	assign ctrl_wr = bus_wr && adr_hit(wb_adr_i, `PIBC_OFS_CTRL);
	assign irq_wr = bus_wr && adr_hit(wb_adr_i, `PIBC_OFS_IRQ_STAT);
	assign mask_wr = irq_wr && wb_sel_i[1];
	always @* begin
		wdata = sel_merge(ctrl_reg, wb_dat_i, wb_sel_i) & `PIBC_CTRL_WMASK;
	end
	// launch fires only on a write that carries bit 0 itself; a byte write to
	// the upper lanes must not re-fire a launch still pending in the register
	assign launch = ctrl_wr && wb_sel_i[0] && wb_dat_i[`PIBC_BIT_LAUNCH];
	assign wipe_wr = ctrl_wr && wdata[`PIBC_BIT_WIPE];
	assign train_launch = launch && ((wdata[15:0] & `PIBC_TRAIN_MASK) != 16'h0000);
	assign engines_idle = !impedance_cal_request_busy && !delay_line_cal_request_busy && !lock_busy;

	// skips act in the write cycle; a request written with its skip is held
	// without starting, so it runs only on a later launch write
	assign impedance_cal_request_stop = ctrl_wr && (wdata[`PIBC_BIT_ZCALSKIP] || wdata[`PIBC_BIT_GSKIP]);
	assign delay_line_cal_request_stop = ctrl_wr && (wdata[`PIBC_BIT_DCALSKIP] || wdata[`PIBC_BIT_GSKIP]);
	assign lock_stop = ctrl_wr && (wdata[`PIBC_BIT_LOCKSKIP] || wdata[`PIBC_BIT_GSKIP]);
	assign impedance_cal_request_start = (launch && wdata[`PIBC_BIT_IMPEDANCE_CAL_REQUEST] && !impedance_cal_request_stop) || (auto_reg && !impedance_cal_request_stop);
	assign delay_line_cal_request_start = (launch && wdata[`PIBC_BIT_DELAY_LINE_CAL_REQUEST] && !delay_line_cal_request_stop) || (auto_reg && !delay_line_cal_request_stop);
	assign lock_start = (launch && wdata[`PIBC_BIT_PLL_LOCK_WAIT_REQUEST] && !lock_stop) || (auto_reg && !lock_stop);

	pibc_routine u_impedance_cal_request (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(impedance_cal_request_start),
		.stop_i(impedance_cal_request_stop),
		.busy_o(impedance_cal_request_busy),
		.done_o(impedance_cal_request_done)
	);
	pibc_routine u_delay_line_cal_request (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(delay_line_cal_request_start),
		.stop_i(delay_line_cal_request_stop),
		.busy_o(delay_line_cal_request_busy),
		.done_o(delay_line_cal_request_done)
	);
	pibc_routine u_lock (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(lock_start),
		.stop_i(lock_stop),
		.busy_o(lock_busy),
		.done_o(lock_done)
	);

	////////////////////////////////////////////////////////////////////////
	// control register next value
	always @* begin
		ctrl_next = ctrl_reg;
		if (ctrl_wr) begin
			ctrl_next = wdata;
			ctrl_next[`PIBC_BIT_GSKIP] = 1'b0;
			ctrl_next[`PIBC_BIT_ZCALSKIP] = 1'b0;
			ctrl_next[`PIBC_BIT_DCALSKIP] = 1'b0;
			ctrl_next[`PIBC_BIT_LOCKSKIP] = 1'b0;
			ctrl_next[`PIBC_BIT_WIPE] = 1'b0;
			if (wdata[`PIBC_BIT_GSKIP]) begin
				ctrl_next[`PIBC_BIT_LAUNCH] = 1'b0;
				for (i = 5; i < 16; i = i + 1) begin
					if (i != `PIBC_BIT_DELAY_LINE_CAL_REQUEST) begin
						ctrl_next[i] = 1'b0;
					end
				end
			end
		end
		if (impedance_cal_request_done) begin
			ctrl_next[`PIBC_BIT_IMPEDANCE_CAL_REQUEST] = 1'b0;
		end
		if (delay_line_cal_request_done) begin
			ctrl_next[`PIBC_BIT_DELAY_LINE_CAL_REQUEST] = 1'b0;
		end
		if (lock_done) begin
			ctrl_next[`PIBC_BIT_PLL_LOCK_WAIT_REQUEST] = 1'b0;
		end
		if (ctrl_reg[`PIBC_BIT_LAUNCH] && engines_idle) begin
			ctrl_next[`PIBC_BIT_LAUNCH] = 1'b0;
			// requests in bits 6 to 15, which have no engine of their own, finish with the launch
			for (i = 6; i < 16; i = i + 1) begin
				ctrl_next[i] = 1'b0;
			end
		end
		ctrl_next[26:19] = 8'h00;
	end

	// general status: done flags set by engines
	always @* begin
		status_next = status_reg;
		if (wipe_wr) begin
			status_next[3:1] = 3'h0;
		end
		if (launch) begin
			status_next[3:1] = 3'h0;
			status_next[`PIBC_ST_FINISHED] = 1'b0;
		end
		if (impedance_cal_request_done) begin
			status_next[`PIBC_ST_ZCALDONE] = 1'b1;
		end
		if (delay_line_cal_request_done) begin
			status_next[`PIBC_ST_DCALDONE] = 1'b1;
		end
		if (lock_done) begin
			status_next[`PIBC_ST_PLLDONE] = 1'b1;
		end
		if ((impedance_cal_request_done || delay_line_cal_request_done || lock_done || (ctrl_reg[`PIBC_BIT_LAUNCH] && !launch))
			&& engines_idle) begin
			status_next[`PIBC_ST_FINISHED] = 1'b1;
		end
	end

	// lane status: set by training hardware, cleared by wipe or new training
	always @* begin
		lane_next = lane_reg;
		if (wipe_wr) begin
			lane_next = 8'h00;
		end
		if (train_launch) begin
			lane_next = 8'h00;
		end
		lane_next = lane_next | lane_status_set_i;
	end

	assign events = {impedance_cal_request_done, delay_line_cal_request_done, lock_done, status_next[`PIBC_ST_FINISHED] &
		~status_reg[`PIBC_ST_FINISHED]};

	////////////////////////////////////////////////////////////////////////
	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ctrl_reg <= `PIBC_CTRL_RESET;
			status_reg <= 4'h0;
			lane_reg <= 8'h00;
			irq_stat_reg <= 4'h0;
			irq_mask_reg <= 4'h0;
			auto_reg <= 1'b1;
			pll_passthrough_o <= 1'b0;
			controller_dram_setup_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			auto_reg <= 1'b0;
			ctrl_reg <= ctrl_next;
			status_reg <= status_next;
			lane_reg <= lane_next;
			pll_passthrough_o <= ctrl_next[`PIBC_BIT_PLLPASS];
			controller_dram_setup_o <= ctrl_next[`PIBC_BIT_CTLSEL];
			// a clear needs byte lane 0; a completion event in the same cycle wins
			if (irq_wr && wb_sel_i[0]) begin
				irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[3:0]) | events;
			end else begin
				irq_stat_reg <= irq_stat_reg | events;
			end
			if (mask_wr) begin
				irq_mask_reg <= wb_dat_i[11:8];
			end
			irq_o <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////
	always @* begin
		case (wb_adr_i)
			`PIBC_OFS_CTRL: rdata = ctrl_reg & `PIBC_CTRL_WMASK;
			`PIBC_OFS_STATUS: rdata = {20'h00000, impedance_cal_request_busy, delay_line_cal_request_busy, lock_busy, 5'h00, status_reg};
			`PIBC_OFS_LANE: rdata = {24'h000000, lane_reg};
			`PIBC_OFS_IRQ_STAT: rdata = {20'h00000, irq_mask_reg, 4'h0, irq_stat_reg};
			default: rdata = 32'h0000_0000;
		endcase
	end

	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_rd) begin
			wb_dat_o <= rdata;
		end
	end
endmodule // pibc_top

// ==== design/pibc_defines.vh ====
// constants for the phy setup control register bank
`ifndef PIBC_DEFINES_VH
`define PIBC_DEFINES_VH
`define PIBC_OFS_CTRL 4'h0
`define PIBC_OFS_STATUS 4'h4
`define PIBC_OFS_LANE 4'h8
`define PIBC_OFS_IRQ_STAT 4'hc
`define PIBC_ADDR_W 4
`define PIBC_BIT_LAUNCH 0
`define PIBC_BIT_IMPEDANCE_CAL_REQUEST 1
`define PIBC_BIT_PLL_LOCK_WAIT_REQUEST 4
`define PIBC_BIT_DELAY_LINE_CAL_REQUEST 5
`define PIBC_BIT_PLLPASS 17
`define PIBC_BIT_CTLSEL 18
`define PIBC_BIT_WIPE 27
`define PIBC_BIT_LOCKSKIP 28
`define PIBC_BIT_DCALSKIP 29
`define PIBC_BIT_ZCALSKIP 30
`define PIBC_BIT_GSKIP 31
`define PIBC_CTRL_RESET 32'h0000_0000
`define PIBC_CTRL_WMASK 32'hf807_ffff
`define PIBC_TRAIN_MASK 16'hfe00
`define PIBC_ST_FINISHED 0
`define PIBC_ST_PLLDONE 1
`define PIBC_ST_DCALDONE 2
`define PIBC_ST_ZCALDONE 3
`define PIBC_ROUTINE_CYC 8'h10
`endif

// ==== design/pibc_routine.v ====
// one calibration routine engine: runs for a fixed time, stoppable
`timescale 1ns/1ps
`include "pibc_defines.vh"
module pibc_routine (
	input wire mclk_i,
	input wire sys_rst_i,
	input wire start_i,
	input wire stop_i,
	output reg busy_o,
	output reg done_o
);
	reg [7:0] cnt_reg;
	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			cnt_reg <= 8'h00;
		end else begin
			done_o <= 1'b0;
			if (stop_i) begin
				busy_o <= 1'b0;
			end else if (start_i) begin
				busy_o <= 1'b1;
				cnt_reg <= `PIBC_ROUTINE_CYC;
			end else if (busy_o) begin
				if (cnt_reg == 8'h01) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end
				cnt_reg <= cnt_reg - 8'h01;
			end
		end
	end
endmodule // pibc_routine

// ==== design/pibc_wb_slave.v ====
// classic wishbone slave handshake: one-cycle ack, one wait state
`timescale 1ns/1ps
module pibc_wb_slave (
	input wire mclk_i,
	input wire sys_rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	output reg ack_o,
	output wire wr_o,
	output wire rd_o
);
	wire req;
	assign req = cyc_i & stb_i & ~ack_o;
	assign wr_o = req & we_i;
	assign rd_o = req & ~we_i;
	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
		end
	end
endmodule // pibc_wb_slave

// ==== test/pibc_monitor.sv ====
// bus and control output checks for the phy setup bank
`timescale 1ns/1ps
module pibc_monitor (
	input wire mclk_i,
	input wire sys_rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire [7:0] lane_status_set_i,
	input wire pll_passthrough_o,
	input wire controller_dram_setup_o,
	input wire irq_o
);
default clocking @(posedge mclk_i); endclocking
default disable iff (sys_rst_i);
wire rq = wb_cyc_i & wb_stb_i & !wb_ack_o;
wire rd = rq & !wb_we_i;
wire cw = rq & wb_we_i & (wb_adr_i == 4'h0) & wb_sel_i[2];
////////////////////////////////
property p_ack; rq |=> wb_ack_o; endproperty
a_ack: assert property (p_ack) else $error("request not answered");
property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
property p_rsv; wb_ack_o && $past(rd && wb_adr_i == 4'h0) |-> wb_dat_o[26:19] == 8'h00; endproperty
a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");
property p_sclr; wb_ack_o && $past(rd && wb_adr_i == 4'h0) |-> wb_dat_o[31:27] == 5'h00; endproperty
a_sclr: assert property (p_sclr) else $error("skip or wipe bit stuck");
property p_pass; cw |=> pll_passthrough_o == $past(wb_dat_i[17]); endproperty
a_pass: assert property (p_pass) else $error("passthrough not written");
property p_ctl; cw |=> controller_dram_setup_o == $past(wb_dat_i[18]); endproperty
a_ctl: assert property (p_ctl) else $error("dram setup select not written");
property p_hold; !cw |=> $stable(pll_passthrough_o) && $stable(controller_dram_setup_o); endproperty
a_hold: assert property (p_hold) else $error("control level changed");
property p_unmap; wb_ack_o && $past(rd && wb_adr_i[1:0] != 2'h0) |-> wb_dat_o == 32'h0; endproperty
a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
property p_dhold; !(wb_ack_o && $past(rd)) |-> $stable(wb_dat_o); endproperty
a_dhold: assert property (p_dhold) else $error("read data moved");
endmodule // pibc_monitor
bind pibc_top pibc_monitor i_mon (.mclk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .lane_status_set_i,
	.pll_passthrough_o, .controller_dram_setup_o, .irq_o);

// ==== test/pibc_tb_top.sv ====
// self-checking bench for the phy setup control bank
`timescale 1ns/1ps
module pibc_tb_top;
reg mclk_i = 1'b0;
reg sys_rst_i = 1'b1;
reg wb_cyc_i = 1'b0;
reg wb_stb_i = 1'b0;
reg wb_we_i = 1'b0;
reg [3:0] wb_adr_i = 4'h0;
reg [3:0] wb_sel_i = 4'h0;
reg [31:0] wb_dat_i = 32'h0;
reg [7:0] lane_status_set_i = 8'h00;
wire [31:0] wb_dat_o;
wire wb_ack_o;
wire pll_passthrough_o;
wire controller_dram_setup_o;
wire irq_o;
integer miscompares = 0;
integer n_compared = 0;
integer cyc_n = 0;
reg [31:0] r;
always #12.5 mclk_i = ~mclk_i;
pibc_top i_dut (.mclk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .lane_status_set_i, .pll_passthrough_o,
	.controller_dram_setup_o, .irq_o);
////////////////////////////////
task give_verdict;
	begin
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	end
endtask
always @(posedge mclk_i) begin
	cyc_n <= cyc_n + 1;
	if (cyc_n == 20000) begin
		miscompares = miscompares + 1;
		give_verdict;
	end
end
task chk(input [31:0] g, input [31:0] e);
	begin
		n_compared = n_compared + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	end
endtask
task wb(input w, input [3:0] a, input [3:0] s, input [31:0] d);
	begin
		@(posedge mclk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		@(posedge mclk_i);
		while (wb_ack_o !== 1'b1) @(posedge mclk_i);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	end
endtask
task rdc(input [3:0] a, input [31:0] m, input [31:0] e);
	begin
		wb(1'b0, a, 4'hf, 32'h0);
		chk(r & m, e);
	end
endtask
task wait_done(input [31:0] m);
	integer k;
	begin
		r = 32'h0;
		for (k = 0; k < 40 && (r & m) !== m; k = k + 1) wb(1'b0, 4'h4, 4'hf, 32'h0);
		chk(r & m, m);
	end
endtask
task pulse_lane(input [7:0] v);
	begin
		@(posedge mclk_i);
		lane_status_set_i <= v;
		@(posedge mclk_i);
		lane_status_set_i <= 8'h00;
	end
endtask
////////////////////////////////
task t_skip;
	begin
		rdc(4'h4, 32'h0000_0e00, 32'h0000_0e00);
		wb(1'b1, 4'h0, 4'h8, 32'h7000_0000);
		rdc(4'h4, 32'h0000_0e00, 32'h0);
		rdc(4'h0, 32'hf800_0000, 32'h0);
	end
endtask
task t_launch;
	begin
		wb(1'b1, 4'h0, 4'hf, 32'h0000_0033);
		rdc(4'h4, 32'h0000_0e00, 32'h0000_0e00);
		wait_done(32'h0000_000f);
		rdc(4'h0, 32'h0000_ffff, 32'h0);
	end
endtask
task t_gskip;
	begin
		wb(1'b1, 4'h0, 4'hf, 32'h0000_0033);
		rdc(4'h4, 32'h0000_000f, 32'h0);
		wb(1'b1, 4'h0, 4'h8, 32'h8000_0000);
		rdc(4'h4, 32'h0000_0e00, 32'h0);
		rdc(4'h0, 32'h8000_0001, 32'h0);
		wb(1'b1, 4'h0, 4'hf, 32'h4000_0002);
		rdc(4'h4, 32'h0000_0800, 32'h0);
		wb(1'b1, 4'h0, 4'hf, 32'h0000_0003);
		rdc(4'h4, 32'h0000_0800, 32'h0000_0800);
		wait_done(32'h0000_0009);
	end
endtask
task t_wipe;
	begin
		pulse_lane(8'ha5);
		rdc(4'h8, 32'h0000_00ff, 32'h0000_00a5);
		wb(1'b1, 4'h0, 4'h8, 32'h0800_0000);
		rdc(4'h8, 32'h0000_00ff, 32'h0);
		rdc(4'h4, 32'h0000_000f, 32'h0000_0001);
		pulse_lane(8'h3c);
		wb(1'b1, 4'h0, 4'hf, 32'h0000_0201);
		rdc(4'h8, 32'h0000_00ff, 32'h0);
		wait_done(32'h0000_0001);
		rdc(4'h0, 32'h0000_ffff, 32'h0);
	end
endtask
task t_ctrl;
	begin
		wb(1'b1, 4'h0, 4'h4, 32'h00ff_0000);
		chk({30'h0, controller_dram_setup_o, pll_passthrough_o}, 32'h3);
		rdc(4'h0, 32'hffff_0000, 32'h0007_0000);
		wb(1'b1, 4'h0, 4'h4, 32'h0);
		chk({30'h0, controller_dram_setup_o, pll_passthrough_o}, 32'h0);
		rdc(4'h2, 32'hffff_ffff, 32'h0);
	end
endtask
task t_irq;
	begin
		rdc(4'hc, 32'h0000_0f0f, 32'h0000_000f);
		chk({31'h0, irq_o}, 32'h0);
		wb(1'b1, 4'hc, 4'h2, 32'h0000_0100);
		repeat (2) @(posedge mclk_i);
		chk({31'h0, irq_o}, 32'h1);
		wb(1'b1, 4'hc, 4'h1, 32'h0000_0001);
		repeat (2) @(posedge mclk_i);
		chk({31'h0, irq_o}, 32'h0);
		rdc(4'hc, 32'h0000_0f0f, 32'h0000_010e);
	end
endtask
initial begin
	repeat (2) @(posedge mclk_i);
	sys_rst_i <= 1'b0;
	t_skip;
	t_launch;
	t_gskip;
	t_wipe;
	t_ctrl;
	t_irq;
	give_verdict;
end
endmodule // pibc_tb_top
